// ---- verilog/lbo_datapath.sv ----
// Execution datapath for AND and single-bit clear/set instructions
module lbo_datapath (
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        resetn_i,
  // Instruction from decoder
  input  wire logic        valid_i,
  input  wire logic [11:0] opcode_i,
  // Operands
  input  wire logic [7:0]  w_i,
  input  wire logic [7:0]  file_rd_data_i,
  // File register read address (combinational to the array)
  output logic [4:0]       file_rd_addr_o,
  // Registered results
  output lbo_pkg::lbo_fwr_t file_wr_o,
  output lbo_pkg::lbo_wwr_t w_wr_o,
  output logic             done_o
);

  ////////////////////////////////////////////////////////////////////////
  // Decode

  lbo_pkg::lbo_op_t op;
  logic [4:0] faddr;
  logic [2:0] bsel;
  logic dest_f;
  logic [7:0] lit;

  assign faddr = opcode_i[lbo_pkg::FADDR_LSB +: lbo_pkg::FADDR_W]; // see RULE4
  assign bsel = opcode_i[lbo_pkg::BIT_LSB +: lbo_pkg::BIT_W]; // see RULE4
  assign dest_f = opcode_i[lbo_pkg::DEST_POS];
  assign lit = opcode_i[lbo_pkg::LIT_LSB +: lbo_pkg::DATA_W];

  always_comb begin
    op = lbo_pkg::LBO_OP_NONE;
    if (valid_i) begin
      if ((opcode_i & lbo_pkg::AND_FILE_MASK) == lbo_pkg::AND_FILE_CODE) begin
        op = lbo_pkg::LBO_OP_AND_FILE;
      end else if ((opcode_i & lbo_pkg::BITOP_MASK) == lbo_pkg::AND_LIT_CODE) begin
        op = lbo_pkg::LBO_OP_AND_LIT;
      end else if ((opcode_i & lbo_pkg::BITOP_MASK) == lbo_pkg::CLRBIT_CODE) begin
        op = lbo_pkg::LBO_OP_CLR_BIT;
      end else if ((opcode_i & lbo_pkg::BITOP_MASK) == lbo_pkg::SETBIT_CODE) begin
        op = lbo_pkg::LBO_OP_SET_BIT;
      end
    end
  end

  // Read port is driven every cycle so the array read settles in the same cycle
  assign file_rd_addr_o = faddr;

  ////////////////////////////////////////////////////////////////////////
  // Execute

  logic [7:0] and_f;
  logic [7:0] and_k;
  logic [7:0] bit_mask;

  assign and_f = w_i & file_rd_data_i; // see RULE1
  assign and_k = w_i & lit; // see RULE5
  assign bit_mask = lbo_pkg::BIT0_MASK << bsel;

  lbo_pkg::lbo_fwr_t fwr_d;
  lbo_pkg::lbo_wwr_t wwr_d;

  always_comb begin
    fwr_d = '0;
    wwr_d = '0;
    // Address only carried with a write strobe; unused fields stay zero
    case (op)
      lbo_pkg::LBO_OP_AND_FILE: begin
        // Z tracks the result whichever destination is chosen
        wwr_d.z_en = 1'b1; // see RULE1
        wwr_d.z_val = (and_f == lbo_pkg::ZERO_BYTE);
        if (dest_f) begin
          fwr_d.en = 1'b1; // see RULE1
          fwr_d.addr = faddr;
          fwr_d.data = and_f;
        end else begin
          wwr_d.w_en = 1'b1; // see RULE1
          wwr_d.w_data = and_f;
        end
      end
      lbo_pkg::LBO_OP_AND_LIT: begin
        wwr_d.w_en = 1'b1; // see RULE5
        wwr_d.w_data = and_k;
        wwr_d.z_en = 1'b1; // see RULE5
        wwr_d.z_val = (and_k == lbo_pkg::ZERO_BYTE);
      end
      lbo_pkg::LBO_OP_CLR_BIT: begin
        fwr_d.en = 1'b1; // see RULE2
        fwr_d.addr = faddr; // see RULE4
        fwr_d.data = file_rd_data_i & ~bit_mask; // see RULE2
      end
      lbo_pkg::LBO_OP_SET_BIT: begin
        fwr_d.en = 1'b1; // see RULE3
        fwr_d.addr = faddr; // see RULE4
        fwr_d.data = file_rd_data_i | bit_mask; // see RULE3
      end
      default: begin
        fwr_d.en = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Result registers: one cycle from issue to write strobe

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      file_wr_o <= '0;
      w_wr_o <= '0;
    end else begin
      file_wr_o <= fwr_d;
      w_wr_o <= wwr_d;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      done_o <= 1'b0;
    end else begin
      done_o <= (op != lbo_pkg::LBO_OP_NONE);
    end
  end

endmodule : lbo_datapath

// ---- verilog/lbo_pkg.sv ----
// Shared constants and carrier types for the logic and bit operations datapath
//
// Functional notes
// RULE1: Register AND: W AND f; d=0 writes W, d=1 writes f; Z only.
// RULE2: Bit clear: zero the selected bit of f; flags untouched; one cycle.
// RULE3: Bit set: one into the selected bit of f; flags untouched; one cycle.
// RULE4: Bit ops decode file address 0..31 and bit position 0..7 from opcode.
// RULE5: Literal AND: W AND 8-bit literal into W, Z only, one cycle.
package lbo_pkg;

  localparam int unsigned OPC_W = 12;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned FADDR_W = 5;
  localparam int unsigned BIT_W = 3;

  // Opcode patterns and masks
  localparam logic [11:0] AND_FILE_MASK = 12'hfc0;
  localparam logic [11:0] AND_FILE_CODE = 12'h140;
  localparam logic [11:0] BITOP_MASK = 12'hf00;
  localparam logic [11:0] CLRBIT_CODE = 12'h400;
  localparam logic [11:0] SETBIT_CODE = 12'h500;
  localparam logic [11:0] AND_LIT_CODE = 12'he00;

  // Field positions
  localparam int unsigned FADDR_LSB = 0;
  localparam int unsigned DEST_POS = 5;
  localparam int unsigned BIT_LSB = 5;
  localparam int unsigned LIT_LSB = 0;

  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] BIT0_MASK = 8'h01;

  typedef enum logic [2:0] {
    LBO_OP_NONE,
    LBO_OP_AND_FILE,
    LBO_OP_AND_LIT,
    LBO_OP_CLR_BIT,
    LBO_OP_SET_BIT
  } lbo_op_t;

  // Write to the file register array
  typedef struct packed {
    logic       en;
    logic [4:0] addr;
    logic [7:0] data;
  } lbo_fwr_t;

  // Write to W and the zero flag
  typedef struct packed {
    logic       w_en;
    logic [7:0] w_data;
    logic       z_en;
    logic       z_val;
  } lbo_wwr_t;

endpackage : lbo_pkg

// ---- verification/lbo_chk.sv ----
// Assertion checker for the logic and bit operations datapath
module lbo_chk (
  // Clock, reset and inputs
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic valid_i,
  input wire logic [11:0] opcode_i,
  input wire logic [7:0] w_i,
  input wire logic [7:0] file_rd_data_i,
  // Outputs
  input wire logic [4:0] file_rd_addr_o,
  input wire lbo_pkg::lbo_fwr_t file_wr_o,
  input wire lbo_pkg::lbo_wwr_t w_wr_o,
  input wire logic done_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  property p_and_file;
    valid_i && opcode_i[11:6] == 6'h05 |=> w_wr_o.z_en && file_wr_o.en == $past(opcode_i[5])
      && w_wr_o.z_val == (($past(w_i) & $past(file_rd_data_i)) == 8'h00);
  endproperty
  property p_clr;
    valid_i && opcode_i[11:8] == 4'h4 |=> done_o && !w_wr_o.z_en
      && file_wr_o.data == ($past(file_rd_data_i) & ~(8'h01 << $past(opcode_i[7:5])));
  endproperty
  property p_set;
    valid_i && opcode_i[11:8] == 4'h5 |=> done_o && !w_wr_o.w_en
      && file_wr_o.data == ($past(file_rd_data_i) | (8'h01 << $past(opcode_i[7:5])));
  endproperty
  // Address is combinational, so it is checked in the same cycle
  property p_addr;
    valid_i && opcode_i[11:9] == 3'b010 |-> file_rd_addr_o == opcode_i[4:0]
      ##1 file_wr_o.en && file_wr_o.addr == $past(opcode_i[4:0]);
  endproperty
  property p_lit;
    valid_i && opcode_i[11:8] == 4'he |=> w_wr_o.w_en && !file_wr_o.en
      && w_wr_o.w_data == ($past(w_i) & $past(opcode_i[7:0]));
  endproperty
  a_and_file: assert property (p_and_file) else $error("and with file wrong");
  a_clr: assert property (p_clr) else $error("bit clear wrong");
  a_set: assert property (p_set) else $error("bit set wrong");
  a_addr: assert property (p_addr) else $error("bit op address wrong");
  a_lit: assert property (p_lit) else $error("and with literal wrong");
  c_and_file: cover property (valid_i && opcode_i[11:6] == 6'h05);
  c_clr: cover property (valid_i && opcode_i[11:8] == 4'h4);
  c_lit: cover property (valid_i && opcode_i[11:8] == 4'he);
endmodule : lbo_chk

bind lbo_datapath lbo_chk u_lbo_chk (.*);

// ---- verification/lbo_files.sv ----
// File register array model facing the datapath
module lbo_files (
  input wire logic clk_sys_i,
  input wire logic [4:0] rd_addr_i,
  input wire lbo_pkg::lbo_fwr_t wr_i,
  output logic [7:0] rd_data_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [32];
  initial foreach (mem[i]) mem[i] = 8'(i * 8'h25);
  // Read is combinational, as the datapath expects
  assign rd_data_o = mem[rd_addr_i];
  always_ff @(posedge clk_sys_i) if (wr_i.en) mem[wr_i.addr] <= wr_i.data;
endmodule : lbo_files

// ---- verification/tb.sv ----
// Random self-checking bench for the logic and bit operations datapath
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_i = 0, resetn_i = 0, valid_i = 0, done_o;
  logic [11:0] opcode_i = 12'h0000;
  logic [7:0] w_i = 8'h00, file_rd_data_i, f, r;
  logic [4:0] file_rd_addr_o;
  lbo_pkg::lbo_fwr_t file_wr_o;
  lbo_pkg::lbo_wwr_t w_wr_o;
  logic [25:0] e = 26'h000_0000;
  int n_fail = 0, compares = 0;
  lbo_datapath u_lbo_datapath (.*);
  lbo_files u_lbo_files (.clk_sys_i(clk_sys_i), .rd_addr_i(file_rd_addr_o), .wr_i(file_wr_o),
    .rd_data_o(file_rd_data_i));
  initial forever #25 clk_sys_i = ~clk_sys_i;
  task chk(input logic [25:0] s, input logic [25:0] x);
    compares++;
    if (s !== x) begin
      n_fail++;
      $display("BAD %0t %h %h", $time, s, x);
    end
  endtask : chk
  task end_of_test;
    if (n_fail == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////////////////////////////////////////////
  // Back to back traffic; file data read live so earlier writes feed later ops
  initial begin
    void'($urandom(32'h5b20));
    repeat (8) @(posedge clk_sys_i);
    #1 resetn_i = 1;
    repeat (3000) begin
      @(posedge clk_sys_i);
      #1 chk({file_wr_o, w_wr_o, done_o}, e);
      valid_i = $urandom % 4 != 0;
      opcode_i = 12'($urandom);
      case ($urandom % 5)
        0: opcode_i[11:6] = 6'h05;
        1: opcode_i[11:8] = 4'h4;
        2: opcode_i[11:8] = 4'h5;
        3: opcode_i[11:8] = 4'he;
        default: ;
      endcase
      w_i = 8'($urandom);
      f = u_lbo_files.mem[opcode_i[4:0]];
      r = w_i & (opcode_i[11:8] == 4'he ? opcode_i[7:0] : f);
      e = 26'h000_0000;
      if (valid_i) case (opcode_i[11:8])
        4'h1: if (opcode_i[7:6] == 2'b01) e = {opcode_i[5], opcode_i[5] ? {opcode_i[4:0], r} :
          13'h0000, !opcode_i[5], opcode_i[5] ? 8'h00 : r, 1'b1, r == 8'h00, 1'b1};
        4'h4: e = {1'b1, opcode_i[4:0], f & ~(8'h01 << opcode_i[7:5]), 11'h000, 1'b1};
        4'h5: e = {1'b1, opcode_i[4:0], f | (8'h01 << opcode_i[7:5]), 11'h000, 1'b1};
        4'he: e = {14'h0000, 1'b1, r, 1'b1, r == 8'h00, 1'b1};
        default: ;
      endcase
    end
    end_of_test();
  end
endmodule : tb
